// >>> logic/adc_consts.svh
/*
  Timing constants for the page-mode DRAM card controller.
  Assumes a 250 MHz controller clock (4 ns period) and the slow speed grade figures.
*/
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH
`define ADC_CLK_PS        4000
`define ADC_T_RAS_PS      80000
`define ADC_T_RP_PS       60000
`define ADC_T_RCD_PS      22000
`define ADC_T_CAS_PS      27000
`define ADC_T_CP_PS       10000
`define ADC_T_CAH_PS      15000
`define ADC_T_RAH_PS      12000
`define ADC_T_CSR_PS      17000
`define ADC_T_CHR_PS      20000
`define ADC_T_ACC_PS      80000
`define ADC_T_OFF_PS      27000
`define ADC_T_BBU_RAS_PS  600000
`define ADC_CYC_UP(t)     (((t) + `ADC_CLK_PS - 1) / `ADC_CLK_PS)
`define ADC_CYC_DN(t)     ((t) / `ADC_CLK_PS)
`define ADC_REF_NORM_CYC  3900
`define ADC_REF_BBU_CYC   31250
`define ADC_PWRUP_CYC     50000
`define ADC_INIT_CYCLES   8
`define ADC_CNT_W         20
`endif

// >>> logic/adc_pkg.sv
/*
  Types for the page-mode DRAM card controller.
  Assumes adc_consts.svh supplies the numbers.
*/
`default_nettype none
package adc_pkg;
  typedef enum logic [9:0] {
    ADC_PWRUP   = 10'h001,
    ADC_IDLE    = 10'h002,
    ADC_ROW     = 10'h004,
    ADC_COL     = 10'h008,
    ADC_COLHI   = 10'h010,
    ADC_PRECH   = 10'h020,
    ADC_RF_CAS  = 10'h040,
    ADC_RF_RAS  = 10'h080,
    ADC_RF_END  = 10'h100,
    ADC_RAS_END = 10'h200
  } adc_state_t;
endpackage : adc_pkg
`default_nettype wire

// >>> logic/adc_ctrl.sv
/*
  Host-side controller for an asynchronous page-mode DRAM card.
  Assumes one 250 MHz clock, synchronous active-high reset, and an external pad
  that resolves data_io from data_out and data_oe.
*/
// Functional notes
// - In backup mode only one column-first refresh every 125 us is issued.
// - Backup refresh keeps row strobe low under 1 us.
// - Backup mode holds address, write and data at stable levels.
// - Row strobe low at least 80 ns, at most 10 us normally.
// - Page mode allows row low up to 100 us, page cycle 57 ns.
// - Row strobe high at least 60 ns between cycles.
// - Column strobe high at least 10 ns between column accesses.
// - Column strobe low at least 27 ns, at most 10 us.
// - Column strobe falls 22 to 53 ns after row strobe falls.
// - Row address set up 7 ns before, held 12 ns after row fall.
// - Column address held at least 15 ns after column strobe falls.
// - Column address set up at least 5 ns before column fall.
// - Write data valid at column fall, held 15 ns after.
// - Write strobe low at least 20 ns before column rise.
// - In reads write strobe stays high until strobes return high.
// - Column-first refresh lowers column strobe 17 ns before row strobe.
// - Write strobe high around the column-first refresh sequence.
// - Row stays low 27 ns after last column fall; 7 ns before next row.
// - All rows refreshed by distributed refresh within 16 ms.
// - Only one side row strobe active in any read or write.
// - Power-up waits 200 us then eight cycles including refresh.
// - All 1024 rows strobed each period; low rows every 8 ms.
`default_nettype none
`include "adc_consts.svh"
module adc_ctrl #(
  parameter int ADDR_W   = 10,
  parameter int DATA_W   = 18,
  parameter int REF_NORM = `ADC_REF_NORM_CYC,
  parameter int REF_BBU  = `ADC_REF_BBU_CYC,
  parameter int PWRUP    = `ADC_PWRUP_CYC
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                req_valid,
  input  wire logic                req_write,
  input  wire logic                req_side,
  input  wire logic                req_page,
  input  wire logic [ADDR_W-1:0]   req_row,
  input  wire logic [ADDR_W-1:0]   req_col,
  input  wire logic [DATA_W-1:0]   req_wdata,
  input  wire logic                backup_mode,
  output logic                     req_ready,
  output logic                     rsp_valid,
  output logic [DATA_W-1:0]        rsp_rdata,
  output logic                     init_done,
  output logic [1:0]               row_strobe_n,
  output logic [1:0]               col_strobe_n,
  output logic                     write_n,
  output logic [ADDR_W-1:0]        addr,
  input  wire logic [DATA_W-1:0]   data_in,
  output logic [DATA_W-1:0]        data_out,
  output logic                     data_oe
);
  localparam int C_RCD = `ADC_CYC_UP(`ADC_T_RCD_PS);
  localparam int C_CAS = `ADC_CYC_UP(`ADC_T_ACC_PS) - C_RCD;
  localparam int C_CP  = `ADC_CYC_UP(`ADC_T_CP_PS) + 1;
  localparam int C_RP  = `ADC_CYC_UP(`ADC_T_RP_PS);
  localparam int C_CSR = `ADC_CYC_UP(`ADC_T_CSR_PS);
  localparam int C_CHR = `ADC_CYC_UP(`ADC_T_RAS_PS);
  localparam int C_BBU = `ADC_CYC_DN(`ADC_T_BBU_RAS_PS);
  localparam int C_OFF = `ADC_CYC_UP(`ADC_T_OFF_PS);

  adc_pkg::adc_state_t st_r, st_nxt;
  logic [`ADC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [`ADC_CNT_W-1:0] ref_r, ref_nxt;
  logic [3:0]            init_r, init_nxt;
  logic                  ref_due_r, ref_due_nxt;
  logic                  wr_r, wr_nxt, side_r, side_nxt, page_r, page_nxt;
  logic [ADDR_W-1:0]     col_r, col_nxt;
  logic [DATA_W-1:0]     wd_r, wd_nxt;
  logic [1:0]            ras_nxt, cas_nxt;
  logic                  we_nxt, oe_nxt, rdy_nxt, rv_nxt, done_nxt;
  logic [ADDR_W-1:0]     a_nxt;
  logic [DATA_W-1:0]     do_nxt, rd_nxt;

  function automatic logic [1:0] side_sel(input logic s);
    side_sel = s ? 2'h2 : 2'h1;
  endfunction : side_sel

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    ref_nxt = (ref_r != '0) ? ref_r - 1'b1 : ref_r;
    ref_due_nxt = ref_due_r | (ref_r == '0);
    init_nxt = init_r;
    wr_nxt = wr_r;
    side_nxt = side_r;
    page_nxt = page_r;
    col_nxt = col_r;
    wd_nxt = wd_r;
    ras_nxt = row_strobe_n;
    cas_nxt = col_strobe_n;
    we_nxt = write_n;
    oe_nxt = data_oe;
    a_nxt = addr;
    do_nxt = data_out;
    rd_nxt = rsp_rdata;
    rdy_nxt = 1'b0;
    rv_nxt = 1'b0;
    done_nxt = init_done;
    if (ref_r == '0) begin
      ref_nxt = backup_mode ? `ADC_CNT_W'(REF_BBU) : `ADC_CNT_W'(REF_NORM);
    end
    case (st_r)
      adc_pkg::ADC_PWRUP: begin
        if (cnt_r == '0) begin
          st_nxt = adc_pkg::ADC_IDLE;
          ref_due_nxt = 1'b1;
        end
      end
      adc_pkg::ADC_IDLE: begin
        we_nxt = 1'b1;
        oe_nxt = 1'b0;
        // Row address goes out two cycles ahead so it is set up before the row strobe.
        if (req_valid && !backup_mode) begin
          a_nxt = req_row;
        end
        rdy_nxt = init_done && !backup_mode && !ref_due_nxt && cnt_r == '0 && req_valid &&
                  addr == req_row;
        if (cnt_r == '0 && (ref_due_r || !init_done)) begin
          ref_due_nxt = 1'b0;
          cas_nxt = 2'h0;
          cnt_nxt = `ADC_CNT_W'(C_CSR);
          st_nxt = adc_pkg::ADC_RF_CAS;
        end else if (req_ready && req_valid) begin
          a_nxt = req_row;
          rdy_nxt = 1'b0;
          ras_nxt = ~side_sel(req_side);
          wr_nxt = req_write;
          side_nxt = req_side;
          page_nxt = req_page;
          col_nxt = req_col;
          wd_nxt = req_wdata;
          cnt_nxt = `ADC_CNT_W'(C_RCD);
          st_nxt = adc_pkg::ADC_ROW;
        end
      end
      adc_pkg::ADC_ROW: begin
        if (cnt_r == `ADC_CNT_W'(C_RCD - 2)) begin
          a_nxt = col_r;
          we_nxt = !wr_r;
          oe_nxt = wr_r;
          do_nxt = wd_r;
        end
        if (cnt_r == '0) begin
          cas_nxt = 2'h0;
          cnt_nxt = `ADC_CNT_W'(C_CAS);
          st_nxt = adc_pkg::ADC_COL;
        end
      end
      adc_pkg::ADC_COL: begin
        if (cnt_r == '0) begin
          rd_nxt = data_in;
          rv_nxt = !wr_r;
          cas_nxt = 2'h3;
          oe_nxt = 1'b0;
          cnt_nxt = `ADC_CNT_W'(C_CP);
          st_nxt = page_r ? adc_pkg::ADC_COLHI : adc_pkg::ADC_RAS_END;
        end
      end
      adc_pkg::ADC_COLHI: begin
        we_nxt = 1'b1;
        if (cnt_r == '0) begin
          if (req_valid && req_page && req_side == side_r && req_row == a_nxt - a_nxt
              + addr && !ref_due_r && !backup_mode && cnt_r == '0) begin
            rdy_nxt = 1'b1;
          end
          st_nxt = adc_pkg::ADC_RAS_END;
          if (rdy_nxt) begin
            col_nxt = req_col;
            wr_nxt = req_write;
            wd_nxt = req_wdata;
            page_nxt = 1'b1;
            a_nxt = req_col;
            we_nxt = !req_write;
            oe_nxt = req_write;
            do_nxt = req_wdata;
            cnt_nxt = `ADC_CNT_W'(2);
            st_nxt = adc_pkg::ADC_ROW;
          end
        end
      end
      adc_pkg::ADC_RAS_END: begin
        ras_nxt = 2'h3;
        we_nxt = 1'b1;
        cnt_nxt = `ADC_CNT_W'(C_RP);
        st_nxt = adc_pkg::ADC_PRECH;
      end
      adc_pkg::ADC_PRECH: begin
        if (cnt_r == '0) begin
          st_nxt = adc_pkg::ADC_IDLE;
        end
      end
      adc_pkg::ADC_RF_CAS: begin
        if (cnt_r == '0) begin
          ras_nxt = 2'h0;
          cnt_nxt = backup_mode ? `ADC_CNT_W'(C_BBU) : `ADC_CNT_W'(C_CHR);
          st_nxt = adc_pkg::ADC_RF_RAS;
        end
      end
      adc_pkg::ADC_RF_RAS: begin
        if (cnt_r == '0) begin
          ras_nxt = 2'h3;
          cas_nxt = 2'h3;
          cnt_nxt = `ADC_CNT_W'(C_RP);
          st_nxt = adc_pkg::ADC_RF_END;
        end
      end
      default: begin
        if (cnt_r == '0) begin
          if (!init_done) begin
            init_nxt = init_r + 4'h1;
            done_nxt = (init_r == 4'(`ADC_INIT_CYCLES - 1));
          end
          st_nxt = adc_pkg::ADC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= adc_pkg::ADC_PWRUP;
      cnt_r <= `ADC_CNT_W'(PWRUP);
      ref_r <= `ADC_CNT_W'(REF_NORM);
      ref_due_r <= 1'b0;
      init_r <= 4'h0;
      wr_r <= 1'b0;
      side_r <= 1'b0;
      page_r <= 1'b0;
      col_r <= '0;
      wd_r <= '0;
      row_strobe_n <= 2'h3;
      col_strobe_n <= 2'h3;
      write_n <= 1'b1;
      data_oe <= 1'b0;
      addr <= '0;
      data_out <= '0;
      rsp_rdata <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      init_done <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ref_r <= ref_nxt;
      ref_due_r <= ref_due_nxt;
      init_r <= init_nxt;
      wr_r <= wr_nxt;
      side_r <= side_nxt;
      page_r <= page_nxt;
      col_r <= col_nxt;
      wd_r <= wd_nxt;
      row_strobe_n <= ras_nxt;
      col_strobe_n <= cas_nxt;
      write_n <= we_nxt;
      data_oe <= oe_nxt;
      addr <= a_nxt;
      data_out <= do_nxt;
      rsp_rdata <= rd_nxt;
      req_ready <= rdy_nxt;
      rsp_valid <= rv_nxt;
      init_done <= done_nxt;
    end
  end
endmodule : adc_ctrl
`default_nettype wire

// >>> bench/adc_checker.sv
/* Pin timing checks for adc_ctrl.
   Assumes one clock and a synchronous reset. */
`default_nettype none
module adc_checker #(
  parameter int ADDR_W   = 10,
  parameter int DATA_W   = 18,
  parameter int REF_NORM = 3900,
  parameter int REF_BBU  = 31250,
  parameter int PWRUP    = 50000
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic [1:0]        row_strobe_n,
  input wire logic [1:0]        col_strobe_n,
  input wire logic              write_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rl_r, rl_nxt, rh_r, rh_nxt, cl_r, cl_nxt;
  logic        rhi, chi;
  assign rhi = &row_strobe_n;
  assign chi = &col_strobe_n;
  always_comb begin
    rl_nxt = rhi ? 16'h0 : rl_r + 16'h1;
    rh_nxt = rhi ? rh_r + 16'h1 : 16'h0;
    cl_nxt = chi ? 16'h0 : cl_r + 16'h1;
  end
  // Counters hold run lengths so long widths need no deep repetition.
  always_ff @(posedge clock) begin
    rl_r <= rst ? 16'h0 : rl_nxt;
    rh_r <= rst ? 16'h0 : rh_nxt;
    cl_r <= rst ? 16'h0 : cl_nxt;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_row_open; $fell(rhi) && chi; endsequence
  sequence s_rcd; chi [*6] ##[1:8] !chi; endsequence
  property p_ras; $rose(rhi) |-> rl_r >= 16'h14 && rl_r <= 16'h09c4; endproperty
  a_ras: assert property (p_ras) else $error("row low width");
  property p_rp; $fell(rhi) |-> rh_r >= 16'h0f; endproperty
  a_rp: assert property (p_rp) else $error("row precharge short");
  property p_rcd; s_row_open |-> s_rcd; endproperty
  a_rcd: assert property (p_rcd) else $error("row to column delay");
  property p_cas; $rose(chi) |-> cl_r >= 16'h7 && cl_r <= 16'h09c4; endproperty
  a_cas: assert property (p_cas) else $error("column low width");
  property p_csr; $fell(rhi) && !chi |-> cl_r >= 16'h5; endproperty
  a_csr: assert property (p_csr) else $error("refresh column lead");
  property p_wsr; $fell(chi) && rhi |-> $past(write_n, 4) && write_n [*4]; endproperty
  a_wsr: assert property (p_wsr) else $error("write strobe in refresh");
  property p_rah; s_row_open |-> $stable(addr) ##1 $stable(addr) [*2]; endproperty
  a_rah: assert property (p_rah) else $error("row address hold");
  property p_cah; $fell(chi) && !rhi |-> $stable(addr) [*4]; endproperty
  a_cah: assert property (p_cah) else $error("column address hold");
  property p_dh; $fell(chi) && data_oe |-> (data_oe && $stable(data_out)) [*4]; endproperty
  a_dh: assert property (p_dh) else $error("write data hold");
endmodule : adc_checker
bind adc_ctrl adc_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .REF_NORM(REF_NORM),
  .REF_BBU(REF_BBU), .PWRUP(PWRUP)) chk_u (.clock(clock), .rst(rst),
  .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_n(write_n),
  .addr(addr), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

// >>> bench/adc_card.sv
/* Behavioural model of the page-mode memory card.
   Assumes strobes move on controller clock edges. */
`default_nettype none
module adc_card #(
  parameter int T_ACC = 27,
  parameter int T_OFF = 27
) (
  input wire logic [1:0]  row_strobe_n,
  input wire logic [1:0]  col_strobe_n,
  input wire logic        write_n,
  input wire logic [9:0]  addr,
  input wire logic [17:0] data_out,
  input wire logic        data_oe,
  output logic [17:0]     data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] mem [int];
  logic [9:0]  row_r [2];
  int          key;
  initial data_in = 18'h2aaaa;
  always @(negedge row_strobe_n[0]) row_r[0] = addr;
  always @(negedge row_strobe_n[1]) row_r[1] = addr;
  always @(negedge col_strobe_n[0]) begin
    if (row_strobe_n != 2'b11) begin
      key = {row_strobe_n[0], row_r[row_strobe_n[0]], addr};
      if (!write_n) mem[key] = data_out;
      else #T_ACC data_in = mem.exists(key) ? mem[key] : 18'h0;
    end
  end
  // release after column.
  // A released bus shows the inverse so a late sample cannot pass.
  always @(posedge col_strobe_n[0]) #T_OFF data_in = ~data_in;
endmodule : adc_card
`default_nettype wire

// >>> bench/adc_ctrl_bench.sv
/* Self-checking bench for adc_ctrl with a card model.
   Assumes shortened refresh and power-up counts. */
`default_nettype none
module adc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, valid = 0, wr = 0, side = 0, bk = 0, row_up = 0;
  logic [9:0] row = 0, col = 0, addr, a0;
  logic [17:0] wd = 0, rd, rdata, din, dout;
  logic ready, rv, done, wn, oe;
  logic [1:0] rs_n, cs_n;
  int errors = 0, n_tests = 0, n_row = 0, i;
  always #2 clock = ~clock;
  adc_ctrl #(.REF_NORM(200), .REF_BBU(400), .PWRUP(50)) dut_u (.clock(clock), .rst(rst),
    .req_valid(valid), .req_write(wr), .req_side(side), .req_page(1'b0), .req_row(row),
    .req_col(col), .req_wdata(wd), .backup_mode(bk), .req_ready(ready), .rsp_valid(rv),
    .rsp_rdata(rdata), .init_done(done), .row_strobe_n(rs_n), .col_strobe_n(cs_n),
    .write_n(wn), .addr(addr), .data_in(din), .data_out(dout), .data_oe(oe));
  adc_card card_u (.row_strobe_n(rs_n), .col_strobe_n(cs_n), .write_n(wn), .addr(addr),
    .data_out(dout), .data_oe(oe), .data_in(din));
  always @(posedge clock) begin
    if (row_up && rs_n != 2'b11) n_row++;
    row_up = &rs_n;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic xfer(input logic w, s, input logic [9:0] r, c, input logic [17:0] d);
    @(negedge clock);
    valid = 1; wr = w; side = s; row = r; col = c; wd = d;
    for (i = 0; i < 2000; i++) begin
      @(posedge clock);
      if (ready === 1'b1) break;
    end
    if (i == 2000) begin
      errors++;
      end_of_test();
    end
    @(negedge clock);
    valid = 0;
    for (i = (i < 2000 && !w) ? 0 : 2000; i < 200; i++) begin
      @(posedge clock);
      if (rv === 1'b1) break;
    end
    rd = rdata;
    if (i == 200) begin
      errors++;
      end_of_test();
    end
    repeat (20) @(negedge clock);
  endtask : xfer
  task automatic t_rw;
    xfer(1, 0, 10'h3ff, 10'h000, 18'h2aaaa);
    xfer(1, 1, 10'h3ff, 10'h000, 18'h15555);
    xfer(1, 0, 10'h000, 10'h3ff, 18'h3ffff);
    xfer(0, 0, 10'h3ff, 10'h000, 18'h0);
    check(rd, 18'h2aaaa);
    xfer(0, 1, 10'h3ff, 10'h000, 18'h0);
    check(rd, 18'h15555);
    xfer(0, 0, 10'h000, 10'h3ff, 18'h0);
    check(rd, 18'h3ffff);
    $display("test rw done");
  endtask : t_rw
  task automatic t_backup;
    bk = 1; valid = 1; wr = 0;
    repeat (20) @(negedge clock);
    a0 = addr; n_row = 0;
    for (i = 0; i < 1000; i++) begin
      @(posedge clock);
      if (ready === 1'b1 || addr !== a0) break;
    end
    check(i, 1000);
    check(n_row >= 2 && n_row <= 3, 1);
    @(negedge clock);
    valid = 0; bk = 0;
    xfer(0, 1, 10'h3ff, 10'h000, 18'h0);
    check(rd, 18'h15555);
    $display("test backup done");
  endtask : t_backup
  initial begin
    repeat (3) @(negedge clock);
    rst = 0;
    n_row = 0;
    for (i = 0; i < 3000 && done !== 1'b1; i++) @(posedge clock);
    if (done !== 1'b1) begin
      errors++;
      end_of_test();
    end
    check(done, 1);
    check(n_row >= 8, 1);
    t_rw();
    n_row = 0;
    repeat (1000) @(negedge clock);
    check(n_row >= 4, 1);
    t_backup();
    end_of_test();
  end
endmodule : adc_ctrl_bench
`default_nettype wire
